// ### hw/dac_pkg.sv
// Functional notes
// - three tri-level straps select the target address
// - address from strap index, zero bits three-two
// - fixed broadcast address 1110011 also accepted
// - straps driven both ways to detect floating
// - acknowledge address only on own/broadcast match
// - three data bytes, each acknowledged on ninth clock
// - execute command only after third byte completes
// - bytes beyond the third are not acknowledged
// - first byte: command high nibble, channel low
// - bytes two and three form left-justified code
// - write loads input register, output register untouched
// - update copies input to output, powers channel
// - commands 0000-0011 write/update; updates power up
// - 0100 powers channels down; 0101 whole chip
// - 0110 selects and powers internal reference
// - 0111 selects external reference, internal off
// - selector 0-3 one channel, 1111 all channels
// - reset reference mode set by build option
// - load pin fall after a completed command updates all; low forces power
// - read requests are never acknowledged
// - power-down commands leave all codes unchanged
// - reference restore depends on what turned it off
package dac_pkg;
  localparam int NUM_CH = 4;
  localparam logic [6:0] GLOBAL_ADDR = 7'h73;
  localparam logic [2:0] ADDR_MSB_BIAS = 3'h1;
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [3:0] CMD_WRITE = 4'h0;
  localparam logic [3:0] CMD_UPDATE = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_PD_CHAN = 4'h4;
  localparam logic [3:0] CMD_PD_CHIP = 4'h5;
  localparam logic [3:0] CMD_REF_INT = 4'h6;
  localparam logic [3:0] CMD_REF_EXT = 4'h7;
  localparam logic [3:0] CMD_NOP = 4'hF;
  localparam logic [3:0] CHAN_ALL = 4'hF;
  localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
  localparam logic [2:0] BYTE_ADDR = 3'h0;
  localparam logic [2:0] BYTE_LAST = 3'h3;
  localparam logic [2:0] BYTE_EXTRA = 3'h4;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [3:0] PWR_RST = 4'hF;
  localparam int CLK_PERIOD_NS = 25;
  localparam int STRAP_SETTLE_NS = 200;
  localparam logic [3:0] STRAP_SETTLE_CYC =
    4'((STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef logic [NUM_CH-1:0][15:0] code_bank_t;
  typedef struct packed {
    logic internal_sel;
    logic powered;
  } ref_status_t;
  typedef enum logic [1:0] {S_IDLE, S_RX, S_ACK, S_SKIP} bus_st_t;
  typedef enum logic [1:0] {P_HI, P_LO, P_DONE} strap_ph_t;
endpackage

// ### hw/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_t;
  sync_t s;
  sync_t next_s;

  always_comb begin
    next_s.meta = d_i;
    next_s.q = s.meta;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= {RST, RST};
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.q;
endmodule
`default_nettype wire

// ### hw/strap_sense.sv
`timescale 1ns/1ps
`default_nettype none
module strap_sense (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_drive_n_o,
  output logic [1:0] level_o,
  output logic done_o
);
  typedef struct packed {
    dac_pkg::strap_ph_t ph;
    logic [3:0] cnt;
    logic hi_seen;
    logic [1:0] level;
  } strap_t;
  localparam strap_t STRAP_RST = '{ph: dac_pkg::P_HI, level: dac_pkg::STRAP_LOW, default: '0};
  strap_t s;
  strap_t next_s;
  logic pin_s;

  pin_sync #(.W(1), .RST(1'b0)) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(pin_i),
    .q_o(pin_s)
  );

  // a tied pin wins over our weak drive; a floating one follows it both ways
  always_comb begin
    next_s = s;
    if (s.ph != dac_pkg::P_DONE) begin
      next_s.cnt = s.cnt + 4'h1;
      if (s.cnt == dac_pkg::STRAP_SETTLE_CYC - 4'h1) begin
        next_s.cnt = '0;
        if (s.ph == dac_pkg::P_HI) begin
          next_s.hi_seen = pin_s;
          next_s.ph = dac_pkg::P_LO;
        end else begin
          next_s.ph = dac_pkg::P_DONE;
          if (s.hi_seen != pin_s) begin
            next_s.level = dac_pkg::STRAP_FLOAT;
          end else if (pin_s) begin
            next_s.level = dac_pkg::STRAP_HIGH;
          end else begin
            next_s.level = dac_pkg::STRAP_LOW;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= STRAP_RST;
    end else begin
      s <= next_s;
    end
  end

  assign pin_o = (s.ph == dac_pkg::P_HI);
  assign pin_drive_n_o = (s.ph == dac_pkg::P_DONE);
  assign level_o = s.level;
  assign done_o = (s.ph == dac_pkg::P_DONE);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_strap_release: assert property (done_o |=> pin_drive_n_o && done_o && $stable(level_o))
    else $error("strap pin driven or level changed after detection");
  a_strap_float: assert property (($rose(done_o) && s.hi_seen != $past(pin_s))
    |-> level_o == dac_pkg::STRAP_FLOAT)
    else $error("strap that followed both drives not sensed as floating");
endmodule
`default_nettype wire

// ### hw/quad_dac_i2c_command_port.sv
`timescale 1ns/1ps
`default_nettype none
module quad_dac_i2c_command_port #(
  parameter bit REF_EXT_DEFAULT = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_drive_n_o,
  input wire logic [2:0] addr_strap_pin_i,
  output logic [2:0] addr_strap_pin_o,
  output logic [2:0] addr_strap_drive_n_o,
  input wire logic strap_pins_12_absent_i,
  input wire logic async_load_pin_n_i,
  output logic [6:0] target_addr_o,
  output logic addr_ready_o,
  output logic command_exec_o,
  output var dac_pkg::code_bank_t input_code_o,
  output var dac_pkg::code_bank_t dac_code_o,
  output logic [3:0] chan_power_o,
  output var dac_pkg::ref_status_t ref_status_o
);
  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic load_q;
    dac_pkg::bus_st_t st;
    logic [3:0] bit_cnt;
    logic [2:0] byte_idx;
    logic [7:0] shreg;
    logic [23:0] word;
    logic ack;
    logic exec;
    logic armed;
    dac_pkg::code_bank_t in_code;
    dac_pkg::code_bank_t dac_code;
    logic [3:0] pwr;
    logic ref_int;
    logic ref_pwr;
    logic ref_chip_off;
  } port_state_t;

  localparam port_state_t STATE_RST = '{
    scl_q: 1'b1,
    sda_q: 1'b1,
    load_q: 1'b1,
    st: dac_pkg::S_IDLE,
    in_code: {dac_pkg::NUM_CH{dac_pkg::CODE_RST}},
    dac_code: {dac_pkg::NUM_CH{dac_pkg::CODE_RST}},
    pwr: dac_pkg::PWR_RST,
    ref_int: !REF_EXT_DEFAULT,
    ref_pwr: !REF_EXT_DEFAULT,
    default: '0
  };

  port_state_t s;
  port_state_t next_s;

  logic [3:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic load_s;
  logic absent_s;
  logic [2:0][1:0] strap_lvl;
  logic [2:0] strap_done;
  logic [1:0] lvl0;
  logic [1:0] lvl1;
  logic [1:0] lvl2;
  logic [4:0] strap_idx;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic load_fall;
  logic load_low;
  logic addr_hit;
  logic byte_ok;
  logic [3:0] cmd;
  logic [3:0] chan;
  logic [15:0] code;
  logic [3:0] sel;

  // scl, sda and the load pin come from the bus side and are resynchronised
  pin_sync #(.W(4), .RST(4'h7)) u_pins (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i({strap_pins_12_absent_i, async_load_pin_n_i, sda_i, scl_i}),
    .q_o(pins_s)
  );
  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign load_s = pins_s[2];
  assign absent_s = pins_s[3];

  for (genvar g = 0; g < 3; g++) begin : g_strap
    strap_sense u_strap (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .pin_i(addr_strap_pin_i[g]),
      .pin_o(addr_strap_pin_o[g]),
      .pin_drive_n_o(addr_strap_drive_n_o[g]),
      .level_o(strap_lvl[g]),
      .done_o(strap_done[g])
    );
  end

  // with only the first strap fitted, the missing two read as tied low
  assign lvl0 = strap_lvl[0];
  assign lvl1 = absent_s ? dac_pkg::STRAP_LOW : strap_lvl[1];
  assign lvl2 = absent_s ? dac_pkg::STRAP_LOW : strap_lvl[2];
  assign strap_idx = 5'({3'h0, lvl2} * 5'd9) + 5'({3'h0, lvl1} * 5'd3) + {3'h0, lvl0};
  assign target_addr_o = {strap_idx[4:2] + dac_pkg::ADDR_MSB_BIAS, 2'b00, strap_idx[1:0]};
  assign addr_ready_o = &strap_done;

  assign scl_rise = scl_s & ~s.scl_q;
  assign scl_fall = ~scl_s & s.scl_q;
  assign bus_start = scl_s & s.scl_q & s.sda_q & ~sda_s;
  assign bus_stop = scl_s & s.scl_q & ~s.sda_q & sda_s;
  assign load_fall = s.load_q & ~load_s;
  assign load_low = ~load_s;

  // read bit set, or no match, leaves the line released
  assign addr_hit = addr_ready_o && !s.shreg[0] &&
    (s.shreg[7:1] == target_addr_o || s.shreg[7:1] == dac_pkg::GLOBAL_ADDR);
  assign byte_ok = (s.byte_idx == dac_pkg::BYTE_ADDR) ? addr_hit :
    (s.byte_idx <= dac_pkg::BYTE_LAST);

  assign cmd = s.word[23:20];
  assign chan = s.word[19:16];
  assign code = s.word[15:0];
  assign sel = (chan == dac_pkg::CHAN_ALL) ? 4'hF :
    (chan[3:2] == 2'b00) ? 4'(4'h1 << chan[1:0]) : 4'h0;

  always_comb begin
    logic [3:0] up;
    up = 4'h0;
    next_s = s;
    next_s.scl_q = scl_s;
    next_s.sda_q = sda_s;
    next_s.load_q = load_s;
    next_s.exec = 1'b0;

    // bus framing; a new START or a STOP drops any partial word
    if (bus_start) begin
      next_s.st = dac_pkg::S_RX;
      next_s.bit_cnt = '0;
      next_s.byte_idx = dac_pkg::BYTE_ADDR;
      next_s.ack = 1'b0;
    end else if (bus_stop) begin
      next_s.st = dac_pkg::S_IDLE;
      next_s.ack = 1'b0;
    end else begin
      case (s.st)
        dac_pkg::S_RX: begin
          if (scl_rise && s.bit_cnt < dac_pkg::BIT_CNT_BYTE) begin
            next_s.shreg = {s.shreg[6:0], sda_s};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end else if (scl_fall && s.bit_cnt == dac_pkg::BIT_CNT_BYTE) begin
            next_s.st = dac_pkg::S_ACK;
            next_s.ack = byte_ok;
            case (s.byte_idx)
              3'h1: next_s.word[23:16] = s.shreg;
              3'h2: next_s.word[15:8] = s.shreg;
              3'h3: next_s.word[7:0] = s.shreg;
              default: ;
            endcase
          end
        end
        dac_pkg::S_ACK: begin
          if (scl_fall) begin
            next_s.ack = 1'b0;
            next_s.bit_cnt = '0;
            if (!s.ack) begin
              next_s.st = dac_pkg::S_SKIP;
            end else begin
              next_s.st = dac_pkg::S_RX;
              next_s.byte_idx = s.byte_idx + 3'h1;
              if (s.byte_idx == dac_pkg::BYTE_LAST) begin
                next_s.exec = 1'b1;
              end
            end
          end
        end
        default: ;
      endcase
    end

    // command execution, one cycle after the third byte's ack ends
    if (s.exec) begin
      next_s.armed = 1'b1;
      case (cmd)
        dac_pkg::CMD_WRITE: begin
          for (int i = 0; i < dac_pkg::NUM_CH; i++) begin
            if (sel[i]) next_s.in_code[i] = code;
          end
        end
        dac_pkg::CMD_UPDATE: begin
          for (int i = 0; i < dac_pkg::NUM_CH; i++) begin
            if (sel[i]) next_s.dac_code[i] = s.in_code[i];
          end
          up = sel;
        end
        dac_pkg::CMD_WRITE_UPD_ALL: begin
          for (int i = 0; i < dac_pkg::NUM_CH; i++) begin
            if (sel[i]) next_s.in_code[i] = code;
          end
          next_s.dac_code = next_s.in_code;
          up = 4'hF;
        end
        dac_pkg::CMD_WRITE_UPDATE: begin
          for (int i = 0; i < dac_pkg::NUM_CH; i++) begin
            if (sel[i]) begin
              next_s.in_code[i] = code;
              next_s.dac_code[i] = code;
            end
          end
          up = sel;
        end
        dac_pkg::CMD_PD_CHAN: begin
          if (!load_low) next_s.pwr = s.pwr & ~sel;
        end
        dac_pkg::CMD_PD_CHIP: begin
          if (!load_low) begin
            next_s.pwr = 4'h0;
            next_s.ref_pwr = 1'b0;
            next_s.ref_chip_off = 1'b1;
          end
        end
        dac_pkg::CMD_REF_INT: begin
          next_s.ref_int = 1'b1;
          next_s.ref_pwr = 1'b1;
          next_s.ref_chip_off = 1'b0;
        end
        dac_pkg::CMD_REF_EXT: begin
          next_s.ref_int = 1'b0;
          next_s.ref_pwr = 1'b0;
          next_s.ref_chip_off = 1'b0;
        end
        default: ;
      endcase
    end

    // load pin: fall after a full write loads all; low holds all powered
    if (load_fall && s.armed) begin
      next_s.dac_code = next_s.in_code;
      // a command finishing in this very cycle keeps the pin armed
      next_s.armed = s.exec;
    end
    if (load_low) up = 4'hF;
    next_s.pwr = next_s.pwr | up;
    // only a chip power-down lets a channel power-up revive the reference
    // next values so a same-cycle reference command is not overridden
    if (up != 4'h0 && next_s.ref_chip_off) begin
      next_s.ref_pwr = next_s.ref_int;
      next_s.ref_chip_off = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign sda_o = 1'b0;
  assign sda_drive_n_o = ~s.ack;
  assign command_exec_o = s.exec;
  assign input_code_o = s.in_code;
  assign dac_code_o = s.dac_code;
  assign chan_power_o = s.pwr;
  assign ref_status_o = '{internal_sel: s.ref_int, powered: s.ref_pwr};

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_ack_addr_match: assert property (($fell(sda_drive_n_o) && s.byte_idx == 3'h0)
    |-> (s.shreg[7:1] == target_addr_o || s.shreg[7:1] == 7'h73))
    else $error("address acknowledged without a match");
  a_no_read_ack: assert property ((!sda_drive_n_o && s.byte_idx == 3'h0) |-> !s.shreg[0])
    else $error("read request acknowledged");
  a_ack_ninth_clk: assert property ($rose(s.ack) |-> $past(scl_fall) && s.bit_cnt == 4'h8)
    else $error("ack not started at the eighth falling clock");
  a_ack_release: assert property ((s.ack && scl_fall && !bus_start && !bus_stop)
    |=> !s.ack ##1 sda_drive_n_o)
    else $error("ack held past the ninth clock");
  a_extra_nak: assert property (s.byte_idx == 3'h4 |-> sda_drive_n_o)
    else $error("extra data byte acknowledged");
  a_exec_third: assert property (s.exec |-> $past(s.byte_idx) == 3'h3 && s.byte_idx == 3'h4)
    else $error("command executed before three bytes");
  a_partial_drop: assert property ((bus_start || bus_stop) |=> !s.exec)
    else $error("command executed after a broken frame");
  a_write_input: assert property ((s.exec && cmd == 4'h0 && !load_fall && sel == 4'h2)
    |=> s.in_code[1] == $past(code) && $stable(s.dac_code))
    else $error("write changed output register or missed input");
  a_update_power: assert property ((s.exec && cmd == 4'h1)
    |=> (s.pwr & $past(sel)) == $past(sel))
    else $error("update left a channel powered down");
  a_load_power: assert property (!load_s |=> s.pwr == 4'hF [*2])
    else $error("channels not powered while load pin is low");
  a_pd_keep_codes: assert property ((s.exec && (cmd == 4'h4 || cmd == 4'h5) && !load_fall)
    |=> $stable(s.in_code) && $stable(s.dac_code))
    else $error("power-down command changed a code");
  a_ext_ref: assert property ((s.exec && cmd == 4'h7) |=> !s.ref_int && !s.ref_pwr)
    else $error("external reference select left internal reference on");
  a_int_ref: assert property ((s.exec && cmd == 4'h6) |=> s.ref_int && s.ref_pwr)
    else $error("internal reference select failed");
endmodule
`default_nettype wire

// ### test/i2c_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
  input wire logic mclk_i,
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // data moves mid-low so it never lands on a clock edge of the target
  task automatic send_bit(input logic b, output logic seen);
    sda_o = b;
    tick(2);
    scl_o = 1'b1;
    tick(3);
    seen = sda_line_i;
    tick(1);
    scl_o = 1'b0;
    tick(2);
  endtask
  task automatic xfer(input logic [6:0] addr, input logic rd, input int n,
      input logic [31:0] data, output logic [4:0] ack);
    logic [7:0] b;
    logic s;
    ack = 5'h1F;
    sda_o = 1'b0;
    tick(4);
    scl_o = 1'b0;
    tick(2);
    for (int k = 0; k <= n; k++) begin
      b = (k == 0) ? {addr, rd} : data[31 - 8 * (k - 1) -: 8];
      for (int i = 7; i >= 0; i--) send_bit(b[i], s);
      send_bit(1'b1, ack[k]);
    end
    sda_o = 1'b0;
    tick(2);
    scl_o = 1'b1;
    tick(4);
    sda_o = 1'b1;
    tick(4);
  endtask
endmodule
`default_nettype wire

// ### test/quad_dac_i2c_command_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module quad_dac_i2c_command_port_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic load_n = 1'b1;
  logic absent = 1'b0;
  logic scl, sda_ctl, dut_sda, sda_drive_n, ready, exec;
  logic [2:0] strap_in, strap_o, strap_drive_n;
  logic [1:0] tie [3] = '{2'h1, 2'h2, 2'h1};
  logic [6:0] taddr;
  logic [3:0] pwr, m_pwr;
  dac_pkg::code_bank_t in_code, dac_code;
  dac_pkg::ref_status_t ref_st;
  logic [15:0] m_in [4];
  logic [15:0] m_dac [4];
  logic m_int, m_on, m_off;
  int error_cnt = 0;
  int compares = 0;
  int exec_cnt = 0;
  wire sda_line = sda_ctl & (sda_drive_n | dut_sda);
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] ch;
    logic [15:0] code;
    logic [3:0] pwr;
    logic [1:0] refs;
  } row_t;
  localparam row_t ROWS [14] = '{
    '{4'h0, 4'h1, 16'hABC0, 4'hF, 2'h3}, '{4'h1, 4'h1, 16'h0000, 4'hF, 2'h3},
    '{4'h3, 4'h2, 16'h1230, 4'hF, 2'h3}, '{4'h4, 4'hF, 16'h7770, 4'h0, 2'h3},
    '{4'h2, 4'h0, 16'h5550, 4'hF, 2'h3}, '{4'h4, 4'h3, 16'h0000, 4'h7, 2'h3},
    '{4'h5, 4'h0, 16'h0000, 4'h0, 2'h2}, '{4'h3, 4'h3, 16'hFFF0, 4'h8, 2'h3},
    '{4'h7, 4'h0, 16'h0000, 4'h8, 2'h0}, '{4'h1, 4'hF, 16'h0000, 4'hF, 2'h0},
    '{4'h6, 4'h0, 16'h0000, 4'hF, 2'h3}, '{4'hF, 4'h0, 16'h1110, 4'hF, 2'h3},
    '{4'h0, 4'h3, 16'h2220, 4'hF, 2'h3}, '{4'h2, 4'h1, 16'h3330, 4'hF, 2'h3}
  };

  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (exec === 1'b1) exec_cnt++;
  // a floating strap follows its drive; once released it shows no stale level
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      if (tie[k] != dac_pkg::STRAP_FLOAT) strap_in[k] = (tie[k] == dac_pkg::STRAP_HIGH);
      else strap_in[k] = strap_drive_n[k] ? ~strap_o[k] : strap_o[k];
    end
  end

  quad_dac_i2c_command_port #(.REF_EXT_DEFAULT(1'b0)) quad_dac_i2c_command_port_inst (
    .mclk_i(mclk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(dut_sda),
    .sda_drive_n_o(sda_drive_n), .addr_strap_pin_i(strap_in), .addr_strap_pin_o(strap_o),
    .addr_strap_drive_n_o(strap_drive_n), .strap_pins_12_absent_i(absent),
    .async_load_pin_n_i(load_n), .target_addr_o(taddr), .addr_ready_o(ready),
    .command_exec_o(exec), .input_code_o(in_code), .dac_code_o(dac_code),
    .chan_power_o(pwr), .ref_status_o(ref_st));
  i2c_ctrl_model i2c_ctrl_model_inst (
    .mclk_i(mclk), .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_ctl));

  task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_regs();
    for (int i = 0; i < 4; i++) begin
      check_val("input code", m_in[i], in_code[i]);
      check_val("output code", m_dac[i], dac_code[i]);
    end
    check_val("power", {12'h000, m_pwr}, {12'h000, pwr});
    check_val("reference", {14'h0000, m_int, m_on}, {14'h0000, ref_st});
  endtask
  task automatic model_cmd(input logic [3:0] cmd, input logic [3:0] ch, input logic [15:0] code);
    logic [3:0] sel;
    logic [3:0] up;
    sel = (ch == 4'hF) ? 4'hF : (ch < 4'h4) ? 4'(1 << ch) : 4'h0;
    up = (cmd == 4'h2) ? 4'hF : (cmd inside {4'h1, 4'h3}) ? sel : 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (sel[i] && cmd inside {4'h0, 4'h2, 4'h3}) m_in[i] = code;
      if ((sel[i] && cmd inside {4'h1, 4'h3}) || cmd == 4'h2) m_dac[i] = m_in[i];
    end
    if (cmd == 4'h4 && load_n) m_pwr &= ~sel;
    if (cmd == 4'h5 && load_n) {m_pwr, m_on, m_off} = 6'b000001;
    if (cmd == 4'h6) {m_int, m_on, m_off} = 3'b110;
    if (cmd == 4'h7) {m_int, m_on, m_off} = 3'b000;
    m_pwr |= up;
    if (up != 4'h0 && m_off) {m_on, m_off} = {m_int, 1'b0};
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (20) @(negedge mclk);
    check_val("strap drive", 16'h0000, {13'h0000, strap_drive_n});
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      m_in[i] = 16'h0000;
      m_dac[i] = 16'h0000;
    end
    {m_pwr, m_int, m_on, m_off} = 7'b1111110;
    for (int i = 0; i < 40 && ready !== 1'b1; i++) @(negedge mclk);
    check_val("strap release", 16'h0007, {13'h0000, strap_drive_n});
    check_regs();
  endtask
  task automatic wr(input logic [6:0] a, input logic [3:0] cmd, input logic [3:0] ch,
      input logic [15:0] code, input int n, output logic [4:0] ack);
    i2c_ctrl_model_inst.xfer(a, 1'b0, n, {cmd, ch, code, 8'h00}, ack);
    repeat (4) @(negedge mclk);
  endtask
  task automatic check_addr(input int idx);
    logic [6:0] e;
    e = {3'(idx / 4 + 1), 2'b00, 2'(idx % 4)};
    check_val("address", {9'h000, e}, {9'h000, taddr});
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    finish_test();
  end

  initial begin
    logic [4:0] ack;
    logic [6:0] a;
    int e;
    do_reset();
    check_addr(16);
    a = {3'h5, 4'h0};
    exec_cnt = 0;
    foreach (ROWS[r]) begin
      wr(a, ROWS[r].cmd, ROWS[r].ch, ROWS[r].code, 3, ack);
      model_cmd(ROWS[r].cmd, ROWS[r].ch, ROWS[r].code);
      check_val("ack", 16'h0000, {12'h000, ack[3:0]});
      check_val("power", {12'h000, ROWS[r].pwr}, {12'h000, pwr});
      check_val("reference", {14'h0000, ROWS[r].refs}, {14'h0000, ref_st});
      check_regs();
    end
    check_val("exec count", 16'h000E, 16'(exec_cnt));
    wr(a ^ 7'h01, 4'h3, 4'h0, 16'h0100, 3, ack);
    check_val("ack", 16'h001F, {11'h000, ack});
    wr(7'h73, 4'h3, 4'hF, 16'h4440, 3, ack);
    model_cmd(4'h3, 4'hF, 16'h4440);
    check_val("ack", 16'h0000, {12'h000, ack[3:0]});
    i2c_ctrl_model_inst.xfer(a, 1'b1, 0, 32'h00000000, ack);
    check_val("read ack", 16'h0001, {15'h0000, ack[0]});
    wr(a, 4'h0, 4'h2, 16'h6660, 4, ack);
    model_cmd(4'h0, 4'h2, 16'h6660);
    check_val("ack", 16'h0010, {11'h000, ack});
    e = exec_cnt;
    wr(a, 4'h0, 4'h0, 16'h9990, 2, ack);
    check_val("exec count", 16'(e), 16'(exec_cnt));
    check_regs();
    wr(a, 4'h0, 4'h0, 16'h8880, 3, ack);
    model_cmd(4'h0, 4'h0, 16'h8880);
    wr(a, 4'h4, 4'hF, 16'h0000, 3, ack);
    model_cmd(4'h4, 4'hF, 16'h0000);
    check_regs();
    load_n = 1'b0;
    repeat (6) @(negedge mclk);
    foreach (m_dac[i]) m_dac[i] = m_in[i];
    m_pwr = 4'hF;
    check_regs();
    wr(a, 4'h4, 4'hF, 16'h0000, 3, ack);
    model_cmd(4'h4, 4'hF, 16'h0000);
    check_regs();
    load_n = 1'b1;
    tie = '{2'h0, 2'h1, 2'h2};
    do_reset();
    check_addr(21);
    tie = '{2'h2, 2'h1, 2'h1};
    absent = 1'b1;
    do_reset();
    check_addr(2);
    wr({3'h1, 4'h2}, 4'h3, 4'h0, 16'h1010, 3, ack);
    model_cmd(4'h3, 4'h0, 16'h1010);
    check_val("ack", 16'h0000, {12'h000, ack[3:0]});
    check_regs();
    finish_test();
  end
endmodule
`default_nettype wire
